// file: src/gia_pkg.sv
// gia_pkg: constants, types and the address decoder of the interrupt aggregator
// assumes a 4 KB register window reached over AXI4-Lite with 32-bit data
package gia_pkg;
  localparam int GIA_NG = 19;
  localparam int GIA_SW = 31;
  localparam int GIA_FIRST_GRP = 8;
  localparam int GIA_WAKE_GRP = 22;
  localparam int GIA_SWI_GRP = 21;
  localparam int GIA_AW = 12;
  localparam logic [11:0] GIA_STRIDE = 12'h014;
  localparam logic [11:0] GIA_SRC_OFF = 12'h000;
  localparam logic [11:0] GIA_SET_OFF = 12'h004;
  localparam logic [11:0] GIA_RES_OFF = 12'h008;
  localparam logic [11:0] GIA_CLR_OFF = 12'h00C;
  localparam logic [11:0] GIA_GRP_END = 12'h17C;
  localparam logic [11:0] GIA_BSET_OFF = 12'h200;
  localparam logic [11:0] GIA_BCLR_OFF = 12'h204;
  localparam logic [11:0] GIA_BVEC_OFF = 12'h208;
  localparam int GIA_BLK_LSB = 8;
  localparam logic [30:0] GIA_SRC_RST = 31'h0000_0000;
  localparam logic [30:0] GIA_EN_RST = 31'h0000_0000;
  localparam logic [18:0] GIA_BLK_RST = 19'h0_0000;
  localparam logic [30:0] GIA_SWI_BITS = 31'h0000_000F;
  localparam logic [1:0] GIA_OKAY = 2'h0;
  localparam logic [1:0] GIA_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    GIA_K_SRC, GIA_K_SET, GIA_K_RES, GIA_K_CLR, GIA_K_RSV,
    GIA_K_BSET, GIA_K_BCLR, GIA_K_BVEC, GIA_K_BAD
  } gia_kind_e;

  typedef struct packed {
    gia_kind_e kind;
    logic [4:0] grp;
  } gia_dec_s;

  // word address to register kind and group index; low two bits ignored
  function automatic gia_dec_s gia_decode(input logic [11:0] a);
    gia_dec_s d;
    logic [11:0] w;
    logic [11:0] sub;
    w = {a[11:2], 2'b00};
    d.kind = GIA_K_BAD;
    d.grp = 5'h00;
    sub = 12'h000;
    if (w < GIA_GRP_END) begin
      d.grp = 5'(w / GIA_STRIDE);
      sub = w % GIA_STRIDE;
      if (sub == GIA_SRC_OFF) d.kind = GIA_K_SRC;
      else if (sub == GIA_SET_OFF) d.kind = GIA_K_SET;
      else if (sub == GIA_RES_OFF) d.kind = GIA_K_RES;
      else if (sub == GIA_CLR_OFF) d.kind = GIA_K_CLR;
      else d.kind = GIA_K_RSV;
    end else if (w == GIA_BSET_OFF) d.kind = GIA_K_BSET;
    else if (w == GIA_BCLR_OFF) d.kind = GIA_K_BCLR;
    else if (w == GIA_BVEC_OFF) d.kind = GIA_K_BVEC;
    return d;
  endfunction
endpackage

// file: src/gia_grp_if.sv
// gia_grp_if: one interrupt group's write strobes and state
// assumes one writer (the register slave) and one group unit
`timescale 1ns/1ps
`default_nettype none
interface gia_grp_if #(parameter int W = 31);
  logic [W-1:0] raw;
  logic [W-1:0] wdata;
  logic wr_src;
  logic wr_set;
  logic wr_clr;
  logic [W-1:0] src;
  logic [W-1:0] en;
  logic [W-1:0] res;
  modport unit (input raw, wdata, wr_src, wr_set, wr_clr, output src, en, res);
  modport ctrl (output raw, wdata, wr_src, wr_set, wr_clr, input src, en, res);
endinterface
`default_nettype wire

// file: src/gia_group.sv
// gia_group: source, enable and result bits of one interrupt group
// assumes raw sources are levels from other logic; strobes last one cycle
`timescale 1ns/1ps
`default_nettype none
module gia_group #(
  parameter int W = 31,
  parameter logic [30:0] IMPL = 31'h7FFF_FFFF
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register side
  gia_grp_if.unit g
);
  import gia_pkg::*;
  logic [W-1:0] s1;
  logic [W-1:0] s2;

  // two-stage capture of the raw sources; s1 feeds only s2
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1 <= '0;
      s2 <= '0;
    end else begin
      s1 <= g.raw; // R11
      s2 <= s1;
    end
  end

  // sticky source bits, one-to-clear; a new event beats the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      g.src <= GIA_SRC_RST;
    end else begin
      g.src <= ((g.src & ~(g.wr_src ? g.wdata : '0)) | s2) & IMPL; // R23 R21
    end
  end

  // one enable word behind two write views, zeros leave bits alone
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      g.en <= GIA_EN_RST;
    end else begin
      g.en <= ((g.en | (g.wr_set ? g.wdata : '0)) & ~(g.wr_clr ? g.wdata : '0)) & IMPL; // R3 R24
    end
  end

  // result is a plain bitwise and, no extra delay
  assign g.res = g.src & g.en; // R4

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_src_sticky: assert property (!g.wr_src |=> ((g.src & $past(g.src)) == $past(g.src))) // R23
    else $error("source bit dropped without a clear");
  a_set_wins: assert property (##1 ((g.src & $past(s2) & IMPL) == ($past(s2) & IMPL))) // R11
    else $error("captured event lost");
  a_en_set: assert property (g.wr_set |=> ((g.en & $past(g.wdata) & IMPL) == ($past(g.wdata) & IMPL))) // R3
    else $error("enable set view failed");
  a_en_clr: assert property (g.wr_clr |=> ((g.en & $past(g.wdata)) == '0)) // R3
    else $error("enable clear view failed");
  a_en_hold: assert property (!g.wr_set && !g.wr_clr |=> g.en == $past(g.en)) // R24
    else $error("enable changed without a write");
  a_impl_rsv: assert property (((g.src | g.en) & ~IMPL) == '0) // R21
    else $error("reserved bit set");
endmodule
`default_nettype wire

// file: src/gia_aggregator.sv
// gia_aggregator: grouped interrupt aggregator with AXI4-Lite registers
// assumes sources are levels synchronous to aclk and one bus master
// Behaviour
// [R1] Gather processor interrupts into group source bits; OR unmasked bits per group.
// [R2] One enable word per group; both set and clear views read it.
// [R3] Set view sets only chosen enable bits; clear view clears only chosen bits.
// [R4] Result bit is source bit AND enable bit, bit by bit.
// [R5] Group request is OR of results, ANDed with its block enable bit.
// [R6] Designated sources drive a direct vector besides the group request.
// [R7] Firmware should not enable group and direct vectors of one group together.
// [R8] With both enabled, one event gives two separate processor interrupts.
// [R9] Software interrupts from the timer have no direct vectors.
// [R10] Every group except group 22 raises a processor interrupt.
// [R11] Sources are captured into bits synchronised to the block clock.
// [R12] Enabled results feed a priority encoder giving the presented vector.
// [R13] Wake-capable sources also drive wake events to the chip wake logic.
// [R14] Pin sources wake only when edge detection is selected.
// [R15] Enabled wake-only events start the fast clock, no processor interrupt.
// [R16] Wake-only events keep sleep permission; clock need drops without interrupts.
// [R17] Wake events are recognised without the block's clock running; here wake_event is registered on aclk.
// [R18] Block requests its clock only when needed.
// [R19] Logic runs on the block clock and resets with system reset.
// [R20] Group number names the processor request it drives.
// [R21] Bits of unimplemented sources are reserved and read zero.
// [R22] Software should use processor masking, not block enables, for critical sections.
// [R23] Source bits are sticky in bits 30:0, cleared by writing one.
// [R24] Writing zero to set or clear views leaves the enable unchanged.
// [R25] Block enable bits 26:8, one per group, set and clear views.
// [R26] Read-only vector field shows group requests, zero when block disabled.
// [R27] Group request is a level while any enabled source bit stays set.
`timescale 1ns/1ps
`default_nettype none
module gia_aggregator #(
  parameter logic [gia_pkg::GIA_NG-1:0][30:0] DIRECT_MASK = '0,
  parameter logic [gia_pkg::GIA_NG-1:0][30:0] WAKE_CAP = '0,
  parameter logic [gia_pkg::GIA_NG-1:0][30:0] IMPL_MASK = '1
) (
  // clock and system reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic [gia_pkg::GIA_AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // axi4-lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [gia_pkg::GIA_AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // interrupt sources and pin edge-detect selection
  input wire logic [gia_pkg::GIA_NG-1:0][gia_pkg::GIA_SW-1:0] src_in,
  input wire logic [gia_pkg::GIA_NG-1:0][gia_pkg::GIA_SW-1:0] edge_sel,
  // processor side
  output logic [gia_pkg::GIA_NG-1:0] agg_irq,
  output logic [gia_pkg::GIA_NG-1:0][gia_pkg::GIA_SW-1:0] direct_irq,
  output logic irq_vec_valid,
  output logic [4:0] irq_vec_num,
  // wake and clock control
  output logic wake_event,
  output logic clk_required,
  output logic sleep_en_keep
);
  import gia_pkg::*;
  localparam int WAKE_IDX = GIA_WAKE_GRP - GIA_FIRST_GRP;
  localparam int SWI_IDX = GIA_SWI_GRP - GIA_FIRST_GRP;

  logic [GIA_SW-1:0] src_a [GIA_NG];
  logic [GIA_SW-1:0] en_a [GIA_NG];
  logic [GIA_SW-1:0] res_a [GIA_NG];
  logic [GIA_NG-1:0] res_or;
  logic [GIA_NG-1:0] next_agg;
  logic [GIA_NG-1:0] blk_en;
  logic aw_got;
  logic w_got;
  logic [GIA_AW-1:0] aw_q;
  logic [31:0] wd_q;
  logic wr_go;
  logic next_aw_got;
  logic next_w_got;
  logic next_bvalid;
  gia_dec_s dw;
  gia_dec_s dr;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic next_vec_valid;
  logic [4:0] next_vec_num;
  logic next_wake;
  logic wake_only_hit;

  // byte strobes turn into a bit mask; unstrobed bits act as zero
  function automatic logic [31:0] gia_strb_mask(input logic [3:0] s);
    logic [31:0] m;
    m = '0;
    for (int b = 0; b < 4; b++) begin
      m[b*8 +: 8] = {8{s[b]}};
    end
    return m;
  endfunction

  // one group unit per interrupt group, register names follow the group number
  genvar gi;
  generate
    for (gi = 0; gi < GIA_NG; gi++) begin : g_grp
      gia_grp_if #(.W(GIA_SW)) gif();
      assign gif.raw = src_in[gi]; // R1
      assign gif.wdata = wd_q[GIA_SW-1:0];
      assign gif.wr_src = wr_go && dw.kind == GIA_K_SRC && dw.grp == 5'(gi); // R20
      assign gif.wr_set = wr_go && dw.kind == GIA_K_SET && dw.grp == 5'(gi);
      assign gif.wr_clr = wr_go && dw.kind == GIA_K_CLR && dw.grp == 5'(gi);
      assign src_a[gi] = gif.src;
      assign en_a[gi] = gif.en;
      assign res_a[gi] = gif.res;
      assign res_or[gi] = |gif.res; // R1
      // wake-only group never raises its group request to the processor
      assign next_agg[gi] = res_or[gi] && blk_en[gi] && (gi != WAKE_IDX); // R5 R10 R27
      gia_group #(.W(GIA_SW), .IMPL(IMPL_MASK[gi])) u_grp (
        .aclk(aclk),
        .aresetn(aresetn),
        .g(gif)
      );
    end
  endgenerate

  // write channel bookkeeping; address and data accepted in either order
  assign dw = gia_decode(aw_q);
  assign wr_go = aw_got && w_got && !bvalid;
  always_comb begin
    next_aw_got = wr_go ? 1'b0 : (aw_got || (awvalid && awready));
    next_w_got = wr_go ? 1'b0 : (w_got || (wvalid && wready));
    next_bvalid = wr_go ? 1'b1 : (bvalid && !bready);
  end

  // write channel registers; ready drops while a word is held or answered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= GIA_OKAY;
      aw_q <= '0;
      wd_q <= '0;
    end else begin
      aw_got <= next_aw_got;
      w_got <= next_w_got;
      awready <= !next_aw_got && !next_bvalid;
      wready <= !next_w_got && !next_bvalid;
      bvalid <= next_bvalid;
      if (awvalid && awready) aw_q <= awaddr;
      if (wvalid && wready) wd_q <= wdata & gia_strb_mask(wstrb);
      if (wr_go) bresp <= (dw.kind == GIA_K_BAD) ? GIA_SLVERR : GIA_OKAY;
    end
  end

  // block enable bits, set and clear views over bits 26:8
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      blk_en <= GIA_BLK_RST; // R19
    end else if (wr_go && dw.kind == GIA_K_BSET) begin
      blk_en <= blk_en | wd_q[GIA_BLK_LSB +: GIA_NG]; // R25
    end else if (wr_go && dw.kind == GIA_K_BCLR) begin
      blk_en <= blk_en & ~wd_q[GIA_BLK_LSB +: GIA_NG]; // R25
    end
  end

  // read mux; holes inside the group area read zero, unmapped addresses outside it answer slverr
  assign dr = gia_decode(araddr);
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_rresp = GIA_OKAY;
    if (dr.kind == GIA_K_SRC) begin
      next_rdata = {1'b0, src_a[dr.grp]};
    end else if (dr.kind == GIA_K_SET || dr.kind == GIA_K_CLR) begin
      next_rdata = {1'b0, en_a[dr.grp]}; // R2
    end else if (dr.kind == GIA_K_RES) begin
      next_rdata = {1'b0, res_a[dr.grp]};
    end else if (dr.kind == GIA_K_BSET || dr.kind == GIA_K_BCLR) begin
      next_rdata = {5'h00, blk_en, 8'h00};
    end else if (dr.kind == GIA_K_BVEC) begin
      next_rdata = {5'h00, agg_irq, 8'h00}; // R26
    end else if (dr.kind == GIA_K_BAD) begin
      next_rresp = GIA_SLVERR;
    end
  end

  // read channel: one read in flight, data captured at the address edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= GIA_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end else if (!rvalid) begin
      arready <= 1'b1;
    end
  end

  // priority encoder: lowest group number wins the presented vector
  always_comb begin
    next_vec_valid = 1'b0;
    next_vec_num = 5'h00;
    for (int i = GIA_NG - 1; i >= 0; i--) begin
      if (next_agg[i]) begin
        next_vec_valid = 1'b1; // R12
        next_vec_num = 5'(i + GIA_FIRST_GRP);
      end
    end
  end

  // wake terms: edge-detect pins and wake-capable sources, plus wake-only group
  always_comb begin
    next_wake = |(src_in & WAKE_CAP & edge_sel); // R13 R14
    next_wake = next_wake || |(src_in[WAKE_IDX] & en_a[WAKE_IDX]); // R15
    wake_only_hit = res_or[WAKE_IDX];
  end

  // processor outputs; direct and group paths run side by side
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      agg_irq <= '0;
      direct_irq <= '0;
      irq_vec_valid <= 1'b0;
      irq_vec_num <= 5'h00;
    end else begin
      agg_irq <= next_agg; // R5 R8
      for (int i = 0; i < GIA_NG; i++) begin
        // timer soft interrupts only travel the group path
        direct_irq[i] <= res_a[i] & DIRECT_MASK[i] & ((i == SWI_IDX) ? ~GIA_SWI_BITS : '1); // R6 R9
      end
      irq_vec_valid <= next_vec_valid;
      irq_vec_num <= next_vec_num;
    end
  end

  // wake and clock control; the wake path bypasses block gating, and enables except on group 22
  // limitation: with one clock the wake output is registered, not asynchronous
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_event <= 1'b0;
      clk_required <= 1'b0;
      sleep_en_keep <= 1'b1;
    end else begin
      wake_event <= next_wake; // R17
      clk_required <= (|next_agg) || wake_only_hit || next_wake; // R18 R16
      sleep_en_keep <= !(|next_agg); // R16
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_agg_gated: assert property (##1 ((agg_irq & ~$past(blk_en)) == '0)) // R5
    else $error("group request while block disabled");
  a_agg_level: assert property (res_or[0] && blk_en[0] |=> agg_irq[0]) // R27
    else $error("group request not held");
  a_wake_grp_quiet: assert property (agg_irq[WAKE_IDX] == 1'b0) // R10
    else $error("wake-only group raised a processor request");
  a_swi_nodirect: assert property ((direct_irq[SWI_IDX] & GIA_SWI_BITS) == '0) // R9
    else $error("soft interrupt on a direct vector");
  a_prio_valid: assert property (irq_vec_valid == (|agg_irq)) // R12
    else $error("vector valid disagrees with requests");
  a_prio_hit: assert property (irq_vec_valid |-> agg_irq[5'(irq_vec_num - 5'd8)]) // R12
    else $error("vector names an idle group");
  a_wake_clk: assert property (wake_only_hit |=> clk_required && sleep_en_keep || (|agg_irq)) // R15
    else $error("wake-only event did not request the clock");
  a_bresp_after: assert property (wr_go |=> bvalid) // R3
    else $error("write not answered");
  c_agg_fire: cover property (|agg_irq);
  c_dual_path: cover property (agg_irq[0] && (|direct_irq[0])); // R8
  c_wake: cover property (wake_event && !(|agg_irq));
  c_slverr: cover property (rvalid && rresp == GIA_SLVERR);
endmodule
`default_nettype wire

// file: verification/gia_vectored_irq_controller_model.sv
// gia_vectored_irq_controller_model: processor interrupt controller and chip wake logic seen from the block
// assumes level requests from the aggregator, registered on aclk
`timescale 1ns/1ps
`default_nettype none
module gia_vectored_irq_controller_model (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // requests from the aggregator
  input wire logic [gia_pkg::GIA_NG-1:0] agg_irq,
  input wire logic [gia_pkg::GIA_NG-1:0][gia_pkg::GIA_SW-1:0] direct_irq,
  input wire logic wake_event,
  // delivered interrupt and wake counts
  output var int n_agg,
  output var int n_dir,
  output var int n_wake
);
  import gia_pkg::*;
  logic [GIA_NG-1:0] agg_q;
  logic [GIA_NG*GIA_SW-1:0] dir_q;
  logic wake_q;
  // a rising level is one delivery; both paths are counted apart, so a double hit shows
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      n_agg <= 0;
      n_dir <= 0;
      n_wake <= 0;
      agg_q <= '0;
      dir_q <= '0;
      wake_q <= 1'b0;
    end else begin
      n_agg <= n_agg + $countones(agg_irq & ~agg_q);
      n_dir <= n_dir + $countones(direct_irq & ~dir_q);
      n_wake <= n_wake + int'(wake_event & ~wake_q);
      agg_q <= agg_irq;
      dir_q <= direct_irq;
      wake_q <= wake_event;
    end
  end
endmodule
`default_nettype wire

// file: verification/test_grouped_interrupt_aggregator.sv
// test_grouped_interrupt_aggregator: self-checking bench driving AXI4-Lite and sources
// assumes the aggregator and the processor-side model; one clock at 100 MHz
`timescale 1ns/1ps
`default_nettype none
module test_grouped_interrupt_aggregator;
  import gia_pkg::*;
  localparam int PW = GIA_NG * GIA_SW;
  // group 9 bit 0 and soft group 21 bit 0 have direct vectors
  localparam logic [PW-1:0] DM = (PW'(1) << 31) | (PW'(1) << 403);
  localparam logic [PW-1:0] WC = PW'(1) << 62; // group 10 bit 0 wakes
  localparam logic [PW-1:0] IM = ~(PW'(1) << 30); // group 8 bit 30 not built
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, irq_vec_valid, wake_event;
  logic clk_required, sleep_en_keep;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rv;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rsp;
  logic [4:0] irq_vec_num;
  logic [GIA_NG-1:0] agg_irq;
  logic [GIA_NG-1:0][GIA_SW-1:0] src_in, edge_sel, direct_irq;
  int failures, n_checks, n_agg, n_dir, n_wake;

  gia_aggregator #(.DIRECT_MASK(DM), .WAKE_CAP(WC), .IMPL_MASK(IM)) dut (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .src_in, .edge_sel, .agg_irq, .direct_irq, .irq_vec_valid, .irq_vec_num,
    .wake_event, .clk_required, .sleep_en_keep);

  gia_vectored_irq_controller_model vectored_irq_controller (.aclk, .aresetn, .agg_irq, .direct_irq, .wake_event,
    .n_agg, .n_dir, .n_wake);

  // free-running clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
      failures++;
    end
  endtask

  // one write; address and data released on their own handshakes, response awaited
  task automatic wreg(input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    rsp = bresp;
    if (i == 40) begin
      failures++;
      conclude();
    end
  endtask

  // one read; data and response taken at the edge that sees rvalid
  task automatic rreg(input logic [11:0] a);
    int i;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    rv = rdata;
    rsp = rresp;
    if (i == 40) begin
      failures++;
      conclude();
    end
  endtask

  function automatic logic [11:0] ga(input int k, input logic [11:0] off);
    return 12'(GIA_STRIDE * 12'(k - 8)) + off;
  endfunction

  // sync plus output register take four edges; six leaves margin
  task automatic settle();
    repeat (6) @(posedge aclk);
  endtask

  task automatic t_reset();
    chk("sleep_keep", 32'(sleep_en_keep), 32'h0000_0001);
    chk("agg_rst", 32'(agg_irq), 32'h0000_0000);
    rreg(ga(10, GIA_SET_OFF));
    chk("en_rst", rv, 32'h0000_0000);
    rreg(GIA_BVEC_OFF);
    chk("vec_rst", rv, 32'h0000_0000);
  endtask

  task automatic t_enable();
    wreg(ga(10, GIA_SET_OFF), 32'h0000_0F0F);
    wreg(ga(10, GIA_CLR_OFF), 32'h0000_0003);
    rreg(ga(10, GIA_SET_OFF));
    chk("en_set_view", rv, 32'h0000_0F0C);
    wreg(ga(10, GIA_SET_OFF), 32'h0000_0000);
    rreg(ga(10, GIA_CLR_OFF));
    chk("en_clr_view", rv, 32'h0000_0F0C);
    wreg(ga(10, GIA_CLR_OFF), 32'h0000_0000);
    rreg(ga(10, GIA_SET_OFF));
    chk("en_zero_wr", rv, 32'h0000_0F0C);
    // only byte 0 strobed: upper set bits must act as zero
    wstrb <= 4'h1;
    wreg(ga(10, GIA_SET_OFF), 32'h0000_F0F3);
    wstrb <= 4'hF;
    rreg(ga(10, GIA_SET_OFF));
    chk("en_strb", rv, 32'h0000_0FFF);
    wreg(ga(10, GIA_CLR_OFF), 32'hFFFF_FFFF);
    rreg(ga(10, GIA_SET_OFF));
    chk("en_all_clr", rv, 32'h0000_0000);
  endtask

  task automatic t_group8();
    wreg(ga(8, GIA_SET_OFF), 32'h0000_0010);
    @(posedge aclk);
    src_in[0][4] <= 1'b1;
    src_in[0][5] <= 1'b1;
    src_in[0][30] <= 1'b1;
    settle();
    rreg(ga(8, GIA_SRC_OFF));
    chk("src8", rv, 32'h0000_0030);
    rreg(ga(8, GIA_RES_OFF));
    chk("res8", rv, 32'h0000_0010);
    chk("agg_blk_off", 32'(agg_irq), 32'h0000_0000);
    wreg(GIA_BSET_OFF, 32'h0000_0100);
    settle();
    chk("agg8", 32'(agg_irq), 32'h0000_0001);
    chk("vec_num8", {irq_vec_valid, 26'h0, irq_vec_num}, 32'h8000_0008);
    chk("clk_req", 32'(clk_required), 32'h0000_0001);
    chk("sleep_drop", 32'(sleep_en_keep), 32'h0000_0000);
    rreg(GIA_BVEC_OFF);
    chk("bvec8", rv, 32'h0000_0100);
    @(posedge aclk);
    src_in[0] <= '0;
    settle();
    chk("agg_sticky", 32'(agg_irq), 32'h0000_0001);
    // block clear only tests gating here, never guards a critical section
    wreg(GIA_BCLR_OFF, 32'h0000_0100);
    settle();
    chk("agg_blk_clr", 32'(agg_irq), 32'h0000_0000);
    rreg(GIA_BVEC_OFF);
    chk("bvec_clr", rv, 32'h0000_0000);
    wreg(GIA_BSET_OFF, 32'h0000_0100);
    wreg(ga(8, GIA_SRC_OFF), 32'h0000_0010);
    settle();
    chk("agg_w1c", 32'(agg_irq), 32'h0000_0000);
    rreg(ga(8, GIA_SRC_OFF));
    chk("src8_w1c", rv, 32'h0000_0020);
  endtask

  task automatic t_direct();
    int a0;
    int d0;
    a0 = n_agg;
    d0 = n_dir;
    // group and direct vectors enabled together on purpose to see the double delivery
    wreg(ga(9, GIA_SET_OFF), 32'h0000_0001);
    wreg(ga(21, GIA_SET_OFF), 32'h0000_0001);
    wreg(GIA_BSET_OFF, 32'h0020_0200);
    @(posedge aclk);
    src_in[1][0] <= 1'b1;
    src_in[13][0] <= 1'b1;
    settle();
    chk("direct9", 32'(direct_irq[1]), 32'h0000_0001);
    chk("direct21", 32'(direct_irq[13]), 32'h0000_0000);
    chk("agg21", 32'(agg_irq), 32'h0000_2002);
    chk("vec_low", 32'(irq_vec_num), 32'h0000_0009);
    chk("n_agg", 32'(n_agg - a0), 32'h0000_0002);
    chk("n_dir", 32'(n_dir - d0), 32'h0000_0001);
    @(posedge aclk);
    src_in[1][0] <= 1'b0;
    src_in[13][0] <= 1'b0;
    wreg(ga(9, GIA_SRC_OFF), 32'h0000_0001);
    wreg(ga(21, GIA_SRC_OFF), 32'h0000_0001);
  endtask

  task automatic t_wake22();
    wreg(ga(22, GIA_SET_OFF), 32'h0000_0001);
    wreg(GIA_BSET_OFF, 32'h0040_0000);
    @(posedge aclk);
    src_in[14][0] <= 1'b1;
    settle();
    chk("wake22", 32'(wake_event), 32'h0000_0001);
    chk("agg22", 32'(agg_irq), 32'h0000_0000);
    chk("vec22", 32'(irq_vec_valid), 32'h0000_0000);
    chk("keep22", 32'(sleep_en_keep), 32'h0000_0001);
    chk("clk22", 32'(clk_required), 32'h0000_0001);
    @(posedge aclk);
    src_in[14][0] <= 1'b0;
    wreg(ga(22, GIA_SRC_OFF), 32'h0000_0001);
    settle();
    chk("clk22_off", 32'(clk_required), 32'h0000_0000);
  endtask

  task automatic t_pinwake();
    int w0;
    w0 = n_wake;
    @(posedge aclk);
    src_in[2][0] <= 1'b1;
    settle();
    chk("wake_level", 32'(wake_event), 32'h0000_0000);
    edge_sel[2][0] <= 1'b1;
    settle();
    chk("wake_edge", 32'(wake_event), 32'h0000_0001);
    chk("n_wake", 32'(n_wake - w0), 32'h0000_0001);
    src_in[2][0] <= 1'b0;
    settle();
    chk("wake_gone", 32'(wake_event), 32'h0000_0000);
  endtask

  task automatic t_bus();
    rreg(12'h180);
    chk("unmapped_r", {rsp, rv[29:0]}, {GIA_SLVERR, 30'h0});
    rreg(12'h010);
    chk("hole_r", {rsp, rv[29:0]}, {GIA_OKAY, 30'h0});
    wreg(12'h300, 32'h0000_0001);
    chk("unmapped_w", 32'(rsp), 32'(GIA_SLVERR));
  endtask

  // reset, then each scenario in turn
  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'hF;
    src_in = '0;
    edge_sel = '0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_enable();
    t_group8();
    t_direct();
    t_wake22();
    t_pinwake();
    t_bus();
    conclude();
  end
endmodule
`default_nettype wire
